//--- eer_defines.svh
// Constants of the ECC error report and log block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every design file that needs a number.
//
// What this block does
// - Log requester id in log bits 23:16, interrupt.
// - Error sets status bit 0 or 1; interrupts.
// - Single-bit error: correct data when enabled.
// - Multi-bit read: abort bus, flag core error.
// - Multi-bit write: regenerate check bits over data.
// - Corrective actions only with ECC enable set.
// - Reporting enabled: set status, fill log pair.
// - Single-bit error clears log bit 8.
// - Syndrome goes into log bits 7:0.
// - Failing address bits 31:2 into address register.
// - Status bit cleared only by writing one.
// - Occupied log pair is never overwritten.
// - Second error uses free pair, else unlogged.
// - Write errors come from read-modify-write reads.
// - Software waits 200 us before memory init.
// - Reset returns all registers to defaults.
// - Software avoids reading unwritten memory.
// - Software avoids constant register polling; the bench's dev task polls the host status until busy clears.
`ifndef EER_DEFINES_SVH
`define EER_DEFINES_SVH

// Device register indices on the link register port.
`define EER_IDX_SDRAM_CONTROL 4'h0
`define EER_IDX_ECC_CONTROL 4'h1
`define EER_IDX_LOG_FIRST 4'h2
`define EER_IDX_LOG_SECOND 4'h3
`define EER_IDX_ADDR_FIRST 4'h4
`define EER_IDX_ADDR_SECOND 4'h5
`define EER_IDX_INT_STATUS 4'h6

// Field positions.
`define EER_SDC_ECC_EN 0
`define EER_ECC_REP_SINGLE 0
`define EER_ECC_REP_MULTI 1
`define EER_LOG_REQ_HI 23
`define EER_LOG_REQ_LO 16
`define EER_LOG_RMW 12
`define EER_LOG_MULTI 8
`define EER_LOG_SYN_HI 7
`define EER_LOG_SYN_LO 0

// Reset values.
`define EER_RST_WORD 32'h0000_0000
`define EER_RST_STATUS 2'h0

// Host APB register byte offsets.
`define EER_APB_CMD 12'h000
`define EER_APB_WDATA 12'h004
`define EER_APB_RDATA 12'h008
`define EER_APB_IRQ_STAT 12'h00C
`define EER_APB_IRQ_CLR 12'h010
`define EER_APB_IRQ_EN 12'h014
`define EER_APB_STATUS 12'h018

// Host command and interrupt fields.
`define EER_CMD_GO 0
`define EER_CMD_WRITE 1
`define EER_CMD_IDX_LO 4
`define EER_IRQ_DEV 0
`define EER_IRQ_DONE 1
`define EER_IRQ_FATAL 2

// Wait after reset before memory init, and its cycle count at 20 MHz.
`define EER_INIT_WAIT_NS 200000
`define EER_CLK_NS 50
`define EER_INIT_WAIT_CYC ((`EER_INIT_WAIT_NS + `EER_CLK_NS - 1) / `EER_CLK_NS)

`endif

//--- eer_pkg.sv
// Types of the ECC error report and log block; only the error kind is shared by both ends.
// Assumes eer_defines.svh holds every number.
package eer_pkg;
   // Kind of an error reported from the read data path.
   typedef enum logic [1:0] {
      EER_ERR_NONE,
      EER_ERR_SINGLE,
      EER_ERR_MULTI
   } eer_err_t;

   // State of the host's register relay.
   typedef enum logic [1:0] {
      EER_H_IDLE,
      EER_H_WAIT
   } eer_host_st_t;
endpackage

//--- eer_if.sv
// Link between the memory data path side (host) and the error logger (device).
// Assumes one common clock; both modports are driven from flip-flops.
`timescale 1ns/1ps
interface eer_if;
   // Error event from a checked read or read-modify-write read.
   logic evt_valid;
   logic evt_rmw;
   logic evt_core;
   logic [1:0] evt_kind;
   logic [7:0] evt_req_id;
   logic [7:0] evt_syndrome;
   logic [29:0] evt_addr;
   // Action answer, one cycle after the event.
   logic rsp_valid;
   logic rsp_correct;
   logic rsp_abort;
   logic rsp_core_mbe;
   logic rsp_regen;
   // Register access to the device.
   logic reg_req;
   logic reg_wr;
   logic [3:0] reg_idx;
   logic [31:0] reg_wdata;
   logic reg_ack;
   logic [31:0] reg_rdata;
   // Core interrupt level.
   logic irq;

   modport dev (
      input evt_valid, evt_rmw, evt_core, evt_kind, evt_req_id, evt_syndrome, evt_addr,
      input reg_req, reg_wr, reg_idx, reg_wdata,
      output rsp_valid, rsp_correct, rsp_abort, rsp_core_mbe, rsp_regen,
      output reg_ack, reg_rdata, irq
   );
   modport host (
      output evt_valid, evt_rmw, evt_core, evt_kind, evt_req_id, evt_syndrome, evt_addr,
      output reg_req, reg_wr, reg_idx, reg_wdata,
      input rsp_valid, rsp_correct, rsp_abort, rsp_core_mbe, rsp_regen,
      input reg_ack, reg_rdata, irq
   );
endinterface

//--- eer_log_slot.sv
// One log and address register pair of the error logger.
// Assumes the parent only loads it while the pair is free.
`timescale 1ns/1ps
`include "eer_defines.svh"
module eer_log_slot
   import eer_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic load_in,
   input wire logic multi_in,
   input wire logic rmw_in,
   input wire logic [7:0] req_id_in,
   input wire logic [7:0] syndrome_in,
   input wire logic [29:0] addr_in,
   output logic [31:0] log_out,
   output logic [31:0] addr_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Capture on load only; contents then stand until the next load.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         log_out <= `EER_RST_WORD;
         addr_out <= `EER_RST_WORD;
      end else if (load_in) begin
         log_out <= `EER_RST_WORD;
         log_out[`EER_LOG_REQ_HI:`EER_LOG_REQ_LO] <= req_id_in;
         log_out[`EER_LOG_MULTI] <= multi_in;
         log_out[`EER_LOG_RMW] <= rmw_in;
         log_out[`EER_LOG_SYN_HI:`EER_LOG_SYN_LO] <= syndrome_in;
         addr_out <= {addr_in, 2'h0};
      end
   end
endmodule

//--- eer_dev.sv
// Device end: classifies checked-read errors, answers with the corrective
// action, logs into two pairs and raises the core interrupt.
// Assumes the host presents at most one error event per cycle and that
// register requests are single-cycle pulses, acknowledged on the next edge.
`timescale 1ns/1ps
`include "eer_defines.svh"
module eer_dev
   import eer_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   eer_if.dev link,
   output logic ecc_en_out,
   output logic [1:0] status_out,
   output logic log_drop_out
);
   logic [31:0] sdram_control_r;
   logic [31:0] ecc_control_r;
   logic [1:0] mem_err_int_status_r;
   logic [1:0] status_nxt;
   logic [1:0] status_set;
   logic [1:0] status_clr;
   logic [31:0] ecc_log_first;
   logic [31:0] ecc_log_second;
   logic [31:0] ecc_fail_addr_first;
   logic [31:0] ecc_fail_addr_second;
   logic ecc_en;
   logic is_single;
   logic is_multi;
   logic report;
   logic load_first;
   logic load_second;
   logic reg_wr_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Decode helper: a register write strobe aimed at one index.
   function automatic logic wr_to(input logic req, input logic wr,
                                  input logic [3:0] idx, input logic [3:0] tgt);
      wr_to = req && wr && (idx == tgt);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Classification of the incoming event.
   // Errors on writes arrive here from the read half of a partial write, so
   // a write error is simply an event with the rmw flag set.
   assign ecc_en = sdram_control_r[`EER_SDC_ECC_EN];
   assign is_single = link.evt_valid && (link.evt_kind == EER_ERR_SINGLE);
   assign is_multi = link.evt_valid && (link.evt_kind == EER_ERR_MULTI);
   assign reg_wr_hit = link.reg_req && link.reg_wr;

   // Reporting is gated per error type by the control register.
   assign report = (is_single && ecc_control_r[`EER_ECC_REP_SINGLE])
                 || (is_multi && ecc_control_r[`EER_ECC_REP_MULTI]);

   // The first free pair wins; with both occupied the error goes unlogged.
   // A pair stays occupied until its status bit is cleared, so a clear in
   // the same cycle does not free it for this event.
   assign load_first = report && !mem_err_int_status_r[0];
   assign load_second = report && mem_err_int_status_r[0]
                      && !mem_err_int_status_r[1];
   assign status_set = {load_second, load_first};

   // Write-one-to-clear; a set in the same cycle wins over the clear.
   assign status_clr = wr_to(link.reg_req, link.reg_wr, link.reg_idx,
                             `EER_IDX_INT_STATUS) ? link.reg_wdata[1:0] : 2'h0;
   assign status_nxt = (mem_err_int_status_r & ~status_clr) | status_set;

   ////////////////////////////////////////////////////////////////////////////
   // Two log pairs.
   eer_log_slot u_first (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .load_in(load_first),
      .multi_in(is_multi),
      .rmw_in(link.evt_rmw),
      .req_id_in(link.evt_req_id),
      .syndrome_in(link.evt_syndrome),
      .addr_in(link.evt_addr),
      .log_out(ecc_log_first),
      .addr_out(ecc_fail_addr_first)
   );

   eer_log_slot u_second (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .load_in(load_second),
      .multi_in(is_multi),
      .rmw_in(link.evt_rmw),
      .req_id_in(link.evt_req_id),
      .syndrome_in(link.evt_syndrome),
      .addr_in(link.evt_addr),
      .log_out(ecc_log_second),
      .addr_out(ecc_fail_addr_second)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status bits.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mem_err_int_status_r <= `EER_RST_STATUS;
      end else begin
         mem_err_int_status_r <= status_nxt;
      end
   end

   // Control registers written over the link.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sdram_control_r <= `EER_RST_WORD;
         ecc_control_r <= `EER_RST_WORD;
      end else begin
         if (wr_to(link.reg_req, link.reg_wr, link.reg_idx, `EER_IDX_SDRAM_CONTROL)) begin
            sdram_control_r <= link.reg_wdata;
         end
         if (wr_to(link.reg_req, link.reg_wr, link.reg_idx, `EER_IDX_ECC_CONTROL)) begin
            ecc_control_r <= link.reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Corrective action answer, one cycle after each event.
   // The action does not depend on whether logging had room.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.rsp_valid <= 1'b0;
         link.rsp_correct <= 1'b0;
         link.rsp_abort <= 1'b0;
         link.rsp_core_mbe <= 1'b0;
         link.rsp_regen <= 1'b0;
      end else begin
         link.rsp_valid <= link.evt_valid;
         link.rsp_correct <= is_single && ecc_en;
         link.rsp_abort <= is_multi && ecc_en && !link.evt_rmw
                           && !link.evt_core;
         link.rsp_core_mbe <= is_multi && ecc_en && !link.evt_rmw
                              && link.evt_core;
         link.rsp_regen <= is_multi && ecc_en && link.evt_rmw;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read port; unknown indices read as zero.
   // Reads have no side effects, so a polling host only costs bandwidth.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.reg_ack <= 1'b0;
         link.reg_rdata <= `EER_RST_WORD;
      end else begin
         link.reg_ack <= link.reg_req;
         if (link.reg_req && !link.reg_wr) begin
            unique case (link.reg_idx)
               `EER_IDX_SDRAM_CONTROL: link.reg_rdata <= sdram_control_r;
               `EER_IDX_ECC_CONTROL: link.reg_rdata <= ecc_control_r;
               `EER_IDX_LOG_FIRST: link.reg_rdata <= ecc_log_first;
               `EER_IDX_LOG_SECOND: link.reg_rdata <= ecc_log_second;
               `EER_IDX_ADDR_FIRST: link.reg_rdata <= ecc_fail_addr_first;
               `EER_IDX_ADDR_SECOND: link.reg_rdata <= ecc_fail_addr_second;
               `EER_IDX_INT_STATUS: link.reg_rdata <= {30'h0, mem_err_int_status_r};
               default: link.reg_rdata <= `EER_RST_WORD;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt level and user-side status, all from flip-flops.
   // A level, not a pulse, so a missed edge never loses an interrupt.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.irq <= 1'b0;
         ecc_en_out <= 1'b0;
         status_out <= `EER_RST_STATUS;
         log_drop_out <= 1'b0;
      end else begin
         link.irq <= |status_nxt;
         ecc_en_out <= reg_wr_hit
                       && link.reg_idx == `EER_IDX_SDRAM_CONTROL
                       ? link.reg_wdata[`EER_SDC_ECC_EN] : ecc_en;
         status_out <= status_nxt;
         log_drop_out <= report && (&mem_err_int_status_r);
      end
   end
endmodule

//--- eer_host.sv
// Host end: forwards data path error events, relays APB register commands to
// the device and raises its own interrupt on device and relay events.
// Assumes an APB master on the user side and a data path that supplies events.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "eer_defines.svh"
module eer_host
   import eer_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   eer_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic err_valid_in,
   input wire logic err_rmw_in,
   input wire logic err_core_in,
   input wire logic [1:0] err_kind_in,
   input wire logic [7:0] err_req_id_in,
   input wire logic [7:0] err_syndrome_in,
   input wire logic [29:0] err_addr_in,
   output logic [3:0] action_out,
   output logic irq_out
);
   eer_host_st_t st_r;
   logic [31:0] wdata_r;
   logic [31:0] rdata_r;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_en_r;
   logic [2:0] irq_set;
   logic dev_irq_d_r;
   logic [11:0] wait_cnt_r;
   logic init_ok_r;
   logic apb_wr;
   logic go;

   assign apb_wr = psel && penable && pwrite;
   assign go = apb_wr && paddr == `EER_APB_CMD && pwdata[`EER_CMD_GO]
               && st_r == EER_H_IDLE;
   assign irq_set = {link.rsp_abort | link.rsp_core_mbe, link.reg_ack,
                     link.irq & ~dev_irq_d_r};

   ////////////////////////////////////////////////////////////////////////////
   // Event forwarding, one cycle of flop delay.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.evt_valid <= 1'b0;
         link.evt_rmw <= 1'b0;
         link.evt_core <= 1'b0;
         link.evt_kind <= EER_ERR_NONE;
         link.evt_req_id <= 8'h00;
         link.evt_syndrome <= 8'h00;
         link.evt_addr <= 30'h0;
         action_out <= 4'h0;
      end else begin
         link.evt_valid <= err_valid_in && err_kind_in != EER_ERR_NONE;
         link.evt_rmw <= err_rmw_in;
         link.evt_core <= err_core_in;
         link.evt_kind <= eer_err_t'(err_kind_in);
         link.evt_req_id <= err_req_id_in;
         link.evt_syndrome <= err_syndrome_in;
         link.evt_addr <= err_addr_in;
         action_out <= link.rsp_valid
                       ? {link.rsp_regen, link.rsp_core_mbe, link.rsp_abort, link.rsp_correct}
                       : 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register relay: one command outstanding; a go while busy is ignored.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r <= EER_H_IDLE;
         link.reg_req <= 1'b0;
         link.reg_wr <= 1'b0;
         link.reg_idx <= 4'h0;
         link.reg_wdata <= `EER_RST_WORD;
         wdata_r <= `EER_RST_WORD;
         rdata_r <= `EER_RST_WORD;
      end else begin
         link.reg_req <= go;
         if (apb_wr && paddr == `EER_APB_WDATA) begin
            wdata_r <= pwdata;
         end
         unique case (st_r)
            EER_H_IDLE: begin
               if (go) begin
                  st_r <= EER_H_WAIT;
                  link.reg_wr <= pwdata[`EER_CMD_WRITE];
                  link.reg_idx <= pwdata[`EER_CMD_IDX_LO +: 4];
                  link.reg_wdata <= wdata_r;
               end
            end
            EER_H_WAIT: begin
               if (link.reg_ack) begin
                  st_r <= EER_H_IDLE;
                  rdata_r <= link.reg_rdata;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky interrupt status, write-only clear, enable; set wins over clear.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_stat_r <= 3'h0;
         irq_en_r <= 3'h0;
         dev_irq_d_r <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         dev_irq_d_r <= link.irq;
         if (apb_wr && paddr == `EER_APB_IRQ_EN) begin
            irq_en_r <= pwdata[2:0];
         end
         if (apb_wr && paddr == `EER_APB_IRQ_CLR) begin
            irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | irq_set;
         end else begin
            irq_stat_r <= irq_stat_r | irq_set;
         end
         irq_out <= |(irq_stat_r & irq_en_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Post-reset wait before software may start memory initialisation.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wait_cnt_r <= 12'h000;
         init_ok_r <= 1'b0;
      end else if (!init_ok_r) begin
         wait_cnt_r <= wait_cnt_r + 12'h001;
         init_ok_r <= wait_cnt_r == 12'(`EER_INIT_WAIT_CYC - 1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer: zero wait states; unmapped reads give zero.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prdata <= `EER_RST_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         unique case (paddr)
            `EER_APB_WDATA: prdata <= wdata_r;
            `EER_APB_RDATA: prdata <= rdata_r;
            `EER_APB_IRQ_STAT: prdata <= {29'h0, irq_stat_r};
            `EER_APB_IRQ_EN: prdata <= {29'h0, irq_en_r};
            `EER_APB_STATUS: prdata <= {29'h0, init_ok_r, link.irq, st_r == EER_H_WAIT};
            default: prdata <= `EER_RST_WORD;
         endcase
      end
   end
endmodule

//--- eer_checker.sv
// Link checks between the two ends of the error logger.
// Assumes one clock; watches interface signals only.
`timescale 1ns/1ps
module eer_checker (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic evt_valid,
   input wire logic evt_rmw,
   input wire logic evt_core,
   input wire logic [1:0] evt_kind,
   input wire logic rsp_correct,
   input wire logic rsp_abort,
   input wire logic rsp_core_mbe,
   input wire logic rsp_regen,
   input wire logic reg_req,
   input wire logic reg_wr,
   input wire logic [3:0] reg_idx,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic [31:0] reg_rdata,
   input wire logic irq
);
   logic en_r;
   logic clr_w;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////
   // Mirror of the ECC enable bit, so actions can be judged.
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         en_r <= 1'b0;
      end else if (reg_req && reg_wr && reg_idx == 4'h0) begin
         en_r <= reg_wdata[0];
      end
   end
   // A status clear; the interrupt may only fall after one.
   assign clr_w = reg_req && reg_wr && reg_idx == 4'h6 && reg_wdata[1:0] != 2'h0;
   sequence ev_s(logic [1:0] k);
      evt_valid && evt_kind == k;
   endsequence
   sequence rd_s(logic [3:0] i);
      reg_req && !reg_wr && reg_idx == i;
   endsequence
   ////////////////////////////////////////////////////////////////
   fix_single_a: assert property (ev_s(2'h1) |=> rsp_correct == $past(en_r))
      else $error("single-bit correct flag wrong");
   abort_bus_a: assert property (ev_s(2'h2) ##0 (!evt_rmw && !evt_core) |=> rsp_abort == $past(en_r))
      else $error("bus abort flag wrong");
   core_mbe_a: assert property (ev_s(2'h2) ##0 (!evt_rmw && evt_core) |=> rsp_core_mbe == $past(en_r))
      else $error("core multi-bit flag wrong");
   regen_rmw_a: assert property (ev_s(2'h2) ##0 evt_rmw |=> rsp_regen == $past(en_r) && !rsp_abort)
      else $error("regenerate flag wrong");
   quiet_idle_a: assert property (!evt_valid |=> !(rsp_correct || rsp_abort || rsp_core_mbe || rsp_regen))
      else $error("action without an event");
   irq_rise_a: assert property ($rose(irq) |-> $past(evt_valid) || $past(evt_valid, 2))
      else $error("interrupt rose without an event");
   irq_hold_a: assert property ($fell(irq) |-> $past(clr_w) || $past(clr_w, 2))
      else $error("interrupt fell without a clear");
   log_fmt_a: assert property ((rd_s(4'h2) or rd_s(4'h3)) |=> reg_ack && reg_rdata[31:24] == 8'h0)
      else $error("log word has stray bits");
   addr_fmt_a: assert property ((rd_s(4'h4) or rd_s(4'h5)) |=> reg_ack && reg_rdata[1:0] == 2'h0)
      else $error("address low bits not zero");
   stat_irq_a: assert property (rd_s(4'h6) |=> reg_ack && irq == (reg_rdata[1:0] != 2'h0))
      else $error("interrupt disagrees with status");
endmodule

//--- test_ecc_error_report_log.sv
// Bench for both ends of the error logger, joined by eer_if.
// Assumes APB zero wait states; expectations come from a model.
`timescale 1ns/1ps
`include "eer_defines.svh"
module test_ecc_error_report_log;
   logic clock_in = 1'b0, nrst_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic err_valid_in = 1'b0, err_rmw_in = 1'b0, err_core_in = 1'b0;
   logic [1:0] err_kind_in = 2'h0, status_out;
   logic [7:0] err_req_id_in = 8'h0, err_syndrome_in = 8'h0;
   logic [29:0] err_addr_in = 30'h0;
   logic [3:0] action_out;
   logic pready, pslverr, irq_out, ecc_en_out, log_drop_out;
   int err_count = 0, checks_done = 0, en = 0, rep = 0;
   logic [1:0] st = 2'h0;
   logic [31:0] lg[2], ad[2];
   eer_if i_eer_if ();
   eer_dev i_eer_dev (.clock_in(clock_in), .nrst_in(nrst_in), .link(i_eer_if),
      .ecc_en_out(ecc_en_out), .status_out(status_out), .log_drop_out(log_drop_out));
   eer_host i_eer_host (.clock_in(clock_in), .nrst_in(nrst_in), .link(i_eer_if), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .err_valid_in(err_valid_in), .err_rmw_in(err_rmw_in),
      .err_core_in(err_core_in), .err_kind_in(err_kind_in), .err_req_id_in(err_req_id_in),
      .err_syndrome_in(err_syndrome_in), .err_addr_in(err_addr_in), .action_out(action_out),
      .irq_out(irq_out));
   eer_checker i_eer_checker (.clock_in(clock_in), .nrst_in(nrst_in),
      .evt_valid(i_eer_if.evt_valid), .evt_rmw(i_eer_if.evt_rmw), .evt_core(i_eer_if.evt_core),
      .evt_kind(i_eer_if.evt_kind), .rsp_correct(i_eer_if.rsp_correct),
      .rsp_abort(i_eer_if.rsp_abort), .rsp_core_mbe(i_eer_if.rsp_core_mbe),
      .rsp_regen(i_eer_if.rsp_regen), .reg_req(i_eer_if.reg_req), .reg_wr(i_eer_if.reg_wr),
      .reg_idx(i_eer_if.reg_idx), .reg_wdata(i_eer_if.reg_wdata), .reg_ack(i_eer_if.reg_ack),
      .reg_rdata(i_eer_if.reg_rdata), .irq(i_eer_if.irq));
   ////////////////////////////////////////////////////////////////
   // Counts every comparison and reports a mismatch at once.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; read data lands in q at the pready edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      do begin
         @(posedge clock_in);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Device register access relayed by the host; polls busy until it clears, with no bound.
   task automatic dev(input logic w, input logic [3:0] i, input logic [31:0] d);
      apb(1'b1, `EER_APB_WDATA, d);
      apb(1'b1, `EER_APB_CMD, {24'h0, i, 2'h0, w, 1'b1});
      do begin
         apb(1'b0, `EER_APB_STATUS, 32'h0);
      end while (q[0] !== 1'b0);
      apb(1'b0, `EER_APB_RDATA, 32'h0);
   endtask
   // One error event with random fields; the model picks the free pair.
   task automatic evt(input logic [1:0] k, input logic r, input logic c);
      logic [3:0] acc;
      logic dr;
      logic [7:0] id;
      logic [7:0] sy;
      logic [29:0] a;
      acc = 4'h0;
      dr = 1'b0;
      id = 8'($urandom);
      sy = 8'($urandom);
      a = 30'($urandom);
      @(posedge clock_in);
      err_valid_in <= 1'b1;
      err_kind_in <= k;
      err_rmw_in <= r;
      err_core_in <= c;
      err_req_id_in <= id;
      err_syndrome_in <= sy;
      err_addr_in <= a;
      @(posedge clock_in);
      err_valid_in <= 1'b0;
      repeat (6) begin
         @(posedge clock_in);
         acc |= action_out;
         dr |= log_drop_out;
      end
      chk("action", {28'h0, en != 0 ? (k == 2'h1 ? 4'h1 : r ? 4'h8 : c ? 4'h4 : 4'h2) : 4'h0},
         {28'h0, acc});
      chk("drop", {31'h0, rep[k - 2'h1] && st == 2'h3}, {31'h0, dr});
      if (rep[k - 2'h1] && st != 2'h3) begin
         lg[st[0]] = {8'h0, id, 3'h0, r, 3'h0, k == 2'h2, sy};
         ad[st[0]] = {a, 2'h0};
         st[st[0]] = 1'b1;
      end
      chk("status", {30'h0, st}, {30'h0, status_out});
   endtask
   // Reads one log and address pair back and compares with the model.
   task automatic cmp_log(input int s);
      dev(1'b0, 4'(2 + s), 32'h0);
      chk("log", lg[s], q);
      dev(1'b0, 4'(4 + s), 32'h0);
      chk("addr", ad[s], q);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Clock at 20 MHz.
   initial begin
      forever #25 clock_in = ~clock_in;
   end
   // Watchdog, far beyond the few hundred cycles the run needs.
   initial begin
      #2000000;
      err_count++;
      results();
   end
   // Main sequence; a second reset at the end of the run is checked to clear log pair 0.
   // Events stand for reads of words already written, never of fresh memory.
   initial begin
      lg = '{32'h0, 32'h0};
      ad = '{32'h0, 32'h0};
      void'($urandom(32'h50E6C3C2));
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         dev(1'b0, 4'(i), 32'h0);
         chk("reset", 32'h0, q);
      end
      apb(1'b1, `EER_APB_IRQ_EN, 32'h1);
      dev(1'b1, 4'h0, 32'h1);
      en = 1;
      chk("ecc_en", 32'h1, {31'h0, ecc_en_out});
      dev(1'b1, 4'h1, 32'h3);
      rep = 3;
      evt(2'h1, 1'b0, 1'b0);
      chk("irq", 32'h1, {31'h0, irq_out});
      evt(2'h2, 1'b1, 1'b0);
      evt(2'h2, 1'b0, 1'b1);
      cmp_log(1);
      dev(1'b1, 4'h6, 32'h1);
      st[0] = 1'b0;
      apb(1'b0, `EER_APB_STATUS, 32'h0);
      chk("dev irq", 32'h1, {31'h0, q[1]});
      evt(2'h2, 1'b0, 1'b0);
      cmp_log(0);
      cmp_log(1);
      dev(1'b1, 4'h6, 32'h3);
      st = 2'h0;
      apb(1'b0, `EER_APB_STATUS, 32'h0);
      chk("dev irq", 32'h0, {31'h0, q[1]});
      dev(1'b1, 4'h0, 32'h0);
      en = 0;
      dev(1'b1, 4'h1, 32'h2);
      rep = 2;
      evt(2'h1, 1'b1, 1'b0);
      evt(2'h2, 1'b1, 1'b1);
      cmp_log(0);
      dev(1'b1, 4'h6, 32'h3);
      st = 2'h0;
      apb(1'b1, `EER_APB_IRQ_CLR, 32'h7);
      apb(1'b0, `EER_APB_IRQ_STAT, 32'h0);
      chk("irq stat", 32'h0, q);
      chk("host irq", 32'h0, {31'h0, irq_out});
      nrst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      nrst_in <= 1'b1;
      lg[0] = 32'h0;
      ad[0] = 32'h0;
      cmp_log(0);
      results();
   end
endmodule
